// file: bench/tb_fog_gate.sv
// self-checking bench for the frequency output sync gate, with a register model
// assumes fog_gate with a zero-wait apb slave, a 25 MHz core clock and sync reset
`timescale 1ns/1ps
module tb_fog_gate
  import fog_pkg::*;
;
  logic        clk, rst, psel, pen, pwr, prem, lock, tick;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, fout, fen;
  logic [1:0]  stat;
  logic [31:0] lfsr;
  int          fails, checked, cyc;
  int          m [5];

  fog_gate dut_u (.I_CORE_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PREMOTE(prem),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_SRC_LOCK(lock),
    .I_MIN_TICK(tick), .O_FREQ_OUT(fout), .O_FREQ_EN(fen), .O_SYNC_STAT(stat));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      give_verdict();
    end
  end

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // model of which writes the register file takes
  function automatic bit ok(input int a, input logic [31:0] d, input logic r);
    case (a)
      0:       return !r && d >= 1 && d <= 32'd10000000;
      4:       return !r && d[15:8] >= 2;
      8:       return !(r && m[4][0]) && d[13:0] >= 2;
      16:      return !r;
      default: return 0;
    endcase
  endfunction : ok

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic r, output logic [31:0] rd, output logic er);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    prem   <= r;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic xfer(input logic w, input int a, input logic [31:0] d, input logic r);
    logic [31:0] rd;
    logic        er;
    bit          good;
    good = w ? ok(a, d, r) : a inside {0, 4, 8, 12, 16};
    apb(w, a[11:0], d, r, rd, er);
    chk("pslverr", {31'h0, !good}, {31'h0, er});
    if (w && good)
      m[a/4] = d & ((a == 16) ? 32'h1 : (a == 4) ? 32'hFFFF : (a == 8) ? 32'h3FFF : 32'hFFFFFFFF);
    if (!w && good)
      chk("prdata", m[a/4], rd);
  endtask : xfer

  task automatic ticks(input int n);
    repeat (n) begin
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask : ticks

  task automatic set_lock(input logic v);
    lock <= v;
    repeat (8) @(posedge clk);
  endtask : set_lock

  task automatic edges(output int n);
    logic prev;
    n = 0;
    prev = fout;
    repeat (1000) begin
      @(posedge clk);
      if (fout !== prev)
        n++;
      prev = fout;
    end
  endtask : edges

  initial begin
    int n;
    int adr [7];
    adr = '{0, 4, 8, 12, 16, 20, 4092};
    m = '{10000000, 32'h0200, 55, 0, 1};
    lfsr = 32'hBEF2;
    {fails, checked} = '0;
    {psel, pen, pwr, prem, lock, tick, paddr, pwdata} = '0;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("freq_en", 0, fen);
    chk("sync_stat", FOG_SRC_LOST, stat);
    foreach (adr[i]) xfer(0, adr[i], 0, 0);
    $display("reset values done");
    xfer(1, 0, 0, 0);
    xfer(1, 0, 10000001, 0);
    xfer(1, 0, 10000000, 0);
    xfer(1, 0, 1, 0);
    xfer(0, 0, 0, 0);
    repeat (4) begin
      lfsr = nxt(lfsr);
      xfer(1, 0, {8'h00, lfsr[23:0]}, 0);
      xfer(0, 0, 0, 0);
    end
    xfer(1, 0, 5, 1);
    xfer(1, 4, 32'h0303, 1);
    xfer(1, 16, 0, 1);
    xfer(1, 16, 0, 0);
    xfer(1, 0, 1000000, 1);
    xfer(1, 16, 1, 0);
    xfer(1, 12, 0, 0);
    xfer(1, 4, 32'h0102, 0);
    xfer(1, 8, 1, 0);
    xfer(1, 8, 2, 0);
    xfer(1, 4, 32'h0202, 0);
    xfer(1, 0, 1000000, 0);
    foreach (adr[i]) xfer(0, adr[i], 0, 0);
    $display("register access done");
    set_lock(1'b1);
    chk("sync_stat", FOG_SYNC, stat);
    ticks(1);
    chk("freq_en", 0, fen);
    set_lock(1'b0);
    set_lock(1'b1);
    ticks(1);
    chk("freq_en", 0, fen);
    ticks(1);
    chk("freq_en", 1, fen);
    edges(n);
    chk("freq_edges", 1, n >= 78 && n <= 82);
    $display("enable done");
    set_lock(1'b0);
    chk("sync_stat", FOG_REG_QTZ, stat);
    ticks(2);
    chk("sync_stat", FOG_QUARTZ, stat);
    chk("freq_en", 1, fen);
    set_lock(1'b1);
    ticks(3);
    chk("freq_en", 1, fen);
    set_lock(1'b0);
    ticks(3);
    chk("freq_en", 1, fen);
    ticks(1);
    chk("freq_en", 0, fen);
    edges(n);
    chk("freq_out_idle", 0, n + fout);
    m[3] = FOG_QUARTZ;
    xfer(0, 12, 0, 0);
    $display("holdover done");
    give_verdict();
  end
endmodule : tb_fog_gate

// file: hdl/fog_gate.sv
// frequency output gating, status holdover timer and apb config registers
// assumes a minute tick from the system clock and a source-lock level from a pin
//
// Contract
// - frequency is settable 1 Hz to 10 MHz in 1 Hz steps and generated at that rate.
// - output stays off until sync status has held unbroken for the on-delay, 0 to 255 min.
// - after sync falls to quartz, output continues for the off-delay, 2 to 255 min.
// - on-delay and off-delay are held as separate settings.
// - writes from the remote configuration path to these settings are refused.
// - on source loss the status passes regulated quartz first, quartz after the sync-off delay.
`timescale 1ns/1ps
`include "fog_params.svh"
module fog_gate
  import fog_pkg::*;
(
  // clock and reset
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_SYS_RST,
  // apb slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  input  wire logic        I_PREMOTE,
  output logic [31:0]      O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // system inputs
  input  wire logic        I_SRC_LOCK,
  input  wire logic        I_MIN_TICK,
  // outputs
  output logic             O_FREQ_OUT,
  output logic             O_FREQ_EN,
  output logic [1:0]       O_SYNC_STAT
);
  fog_cfg_t    cfg_reg;
  fog_cfg_t    cfg_next;
  fog_stat_t   stat_reg;
  fog_stat_t   stat_next;
  fog_gate_t   gate_reg;
  fog_gate_t   gate_next;
  logic [13:0] soff_cnt_reg;
  logic [13:0] soff_cnt_next;
  logic [7:0]  cnt_reg;
  logic [7:0]  cnt_next;
  logic        lock_s1_reg;
  logic        lock_s2_reg;
  logic        rd_err;
  logic        wr_err;
  logic        access;
  logic [31:0] rdata;

  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == `FOG_ADDR_FREQ) || (a == `FOG_ADDR_DELAY) || (a == `FOG_ADDR_SYNCOFF)
              || (a == `FOG_ADDR_STATUS) || (a == `FOG_ADDR_CTRL);
  endfunction : addr_known

  // two-flop synchroniser for the lock pin
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      lock_s1_reg <= 1'b0;
      lock_s2_reg <= 1'b0;
    end else begin
      lock_s1_reg <= I_SRC_LOCK;
      lock_s2_reg <= lock_s1_reg;
    end
  end

  assign access    = I_PSEL & I_PENABLE;
  assign O_PREADY  = 1'b1;

  // register writes
  always_comb begin
    cfg_next = cfg_reg;
    wr_err   = 1'b0;
    if (access && I_PWRITE) begin
      if (!addr_known(I_PADDR) || (I_PADDR == `FOG_ADDR_STATUS)) begin
        wr_err = 1'b1;
      end else if (I_PREMOTE && (I_PADDR != `FOG_ADDR_CTRL)
                   && (cfg_reg.remote_lock || (I_PADDR == `FOG_ADDR_FREQ)
                       || (I_PADDR == `FOG_ADDR_DELAY))) begin
        // frequency and delay settings never taken from the remote path
        wr_err = 1'b1;
      end else begin
        unique case (I_PADDR)
          `FOG_ADDR_FREQ: begin
            // out-of-range settings refused
            if ((I_PWDATA[23:0] < `FOG_FREQ_MIN) || (I_PWDATA[23:0] > `FOG_FREQ_MAX)
                || (I_PWDATA[31:24] != 8'h00)) begin
              wr_err = 1'b1;
            end else begin
              cfg_next.freq = I_PWDATA[23:0];
            end
          end
          `FOG_ADDR_DELAY: begin
            if (I_PWDATA[`FOG_OFF_LSB+:8] < `FOG_OFF_MIN) begin
              wr_err = 1'b1;
            end else begin
              cfg_next.on_min  = I_PWDATA[`FOG_ON_LSB+:8];
              cfg_next.off_min = I_PWDATA[`FOG_OFF_LSB+:8];
            end
          end
          `FOG_ADDR_SYNCOFF: begin
            if (I_PWDATA[13:0] < `FOG_SYNCOFF_MIN) begin
              wr_err = 1'b1;
            end else begin
              cfg_next.syncoff_min = I_PWDATA[13:0];
            end
          end
          `FOG_ADDR_CTRL: begin
            if (I_PREMOTE) begin
              wr_err = 1'b1;
            end else begin
              cfg_next.remote_lock = I_PWDATA[0];
            end
          end
          default: wr_err = 1'b1;
        endcase
      end
    end
  end

  // read mux
  always_comb begin
    rdata  = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (I_PADDR)
      `FOG_ADDR_FREQ:    rdata = {8'h00, cfg_reg.freq};
      `FOG_ADDR_DELAY:   rdata = {16'h0000, cfg_reg.off_min, cfg_reg.on_min};
      `FOG_ADDR_SYNCOFF: rdata = {18'h00000, cfg_reg.syncoff_min};
      `FOG_ADDR_STATUS:  rdata = {16'h0000, cnt_reg, 4'h0, gate_reg, stat_reg};
      `FOG_ADDR_CTRL:    rdata = {31'h0000_0000, cfg_reg.remote_lock};
      default:           rd_err = 1'b1;
    endcase
  end

  assign O_PSLVERR = access & (I_PWRITE ? wr_err : rd_err);
  assign O_PRDATA  = (access && !I_PWRITE && !rd_err) ? rdata : 32'h0000_0000;

  // sync status with regulated quartz holdover
  always_comb begin
    stat_next     = stat_reg;
    soff_cnt_next = soff_cnt_reg;
    if (lock_s2_reg) begin
      stat_next     = FOG_SYNC;
      soff_cnt_next = 14'h0000;
    end else begin
      unique case (stat_reg)
        FOG_SYNC: begin
          stat_next     = FOG_REG_QTZ;
          soff_cnt_next = 14'h0000;
        end
        FOG_REG_QTZ: begin
          if (I_MIN_TICK) begin
            soff_cnt_next = soff_cnt_reg + 14'h0001;
            if (soff_cnt_next >= cfg_reg.syncoff_min) begin
              stat_next = FOG_QUARTZ;
            end
          end
        end
        FOG_QUARTZ:   stat_next = FOG_QUARTZ;
        FOG_SRC_LOST: stat_next = FOG_SRC_LOST;
      endcase
    end
  end

  // output gate
  always_comb begin
    gate_next = gate_reg;
    cnt_next  = cnt_reg;
    unique case (gate_reg)
      FOG_G_OFF: begin
        cnt_next = 8'h00;
        if (stat_reg == FOG_SYNC) begin
          gate_next = (cfg_reg.on_min == 8'h00) ? FOG_G_ON : FOG_G_WAIT;
        end
      end
      FOG_G_WAIT: begin
        if (stat_reg != FOG_SYNC) begin
          gate_next = FOG_G_OFF;
        end else if (I_MIN_TICK) begin
          cnt_next = cnt_reg + 8'h01;
          if (cnt_next >= cfg_reg.on_min) begin
            gate_next = FOG_G_ON;
          end
        end
      end
      FOG_G_ON: begin
        cnt_next = 8'h00;
        if (stat_reg == FOG_QUARTZ) begin
          gate_next = FOG_G_HOLD;
        end
      end
      FOG_G_HOLD: begin
        if (stat_reg == FOG_SYNC) begin
          gate_next = FOG_G_ON;
          cnt_next  = 8'h00;
        end else if (I_MIN_TICK) begin
          cnt_next = cnt_reg + 8'h01;
          if (cnt_next >= cfg_reg.off_min) begin
            gate_next = FOG_G_OFF;
          end
        end
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      cfg_reg.freq        <= `FOG_FREQ_RST;
      cfg_reg.on_min      <= `FOG_ON_RST;
      cfg_reg.off_min     <= `FOG_OFF_RST;
      cfg_reg.syncoff_min <= `FOG_SYNCOFF_RST;
      cfg_reg.remote_lock <= 1'b1;
      stat_reg            <= FOG_SRC_LOST;
      soff_cnt_reg        <= 14'h0000;
      gate_reg            <= FOG_G_OFF;
      cnt_reg             <= 8'h00;
    end else begin
      cfg_reg      <= cfg_next;
      stat_reg     <= stat_next;
      soff_cnt_reg <= soff_cnt_next;
      gate_reg     <= gate_next;
      cnt_reg      <= cnt_next;
    end
  end

  logic en_reg;
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      en_reg <= 1'b0;
    end else begin
      en_reg <= (gate_next == FOG_G_ON) || (gate_next == FOG_G_HOLD);
    end
  end

  fog_nco u_nco (
    .i_clk  (I_CORE_CLK),
    .i_rst  (I_SYS_RST),
    .i_run  (en_reg),
    .i_freq (cfg_reg.freq),
    .o_wave (O_FREQ_OUT)
  );

  assign O_FREQ_EN   = en_reg;
  assign O_SYNC_STAT = stat_reg;

  // assertions
  sequence s_sync_lost;
    (gate_reg == FOG_G_ON) ##1 (stat_reg == FOG_QUARTZ);
  endsequence

  property p_no_en_without_sync;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      $rose(en_reg) |-> $past(stat_reg == FOG_SYNC);
  endproperty
  a_no_en_without_sync: assert property (p_no_en_without_sync)
    else $error("output enabled without sync status");

  property p_hold_after_quartz;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      s_sync_lost |=> (gate_reg == FOG_G_HOLD) && en_reg;
  endproperty
  a_hold_after_quartz: assert property (p_hold_after_quartz)
    else $error("output not held after quartz entry");

  property p_remote_refused;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (access && I_PWRITE && I_PREMOTE
       && ((I_PADDR == `FOG_ADDR_DELAY) || (I_PADDR == `FOG_ADDR_FREQ)))
      |=> $stable(cfg_reg.on_min) && $stable(cfg_reg.off_min) && $stable(cfg_reg.freq);
  endproperty
  a_remote_refused: assert property (p_remote_refused)
    else $error("remote write changed delay settings");

  property p_regqtz_first;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (stat_reg == FOG_SYNC) && !lock_s2_reg |=> (stat_reg == FOG_REG_QTZ);
  endproperty
  a_regqtz_first: assert property (p_regqtz_first)
    else $error("sync did not pass through regulated quartz");

  property p_off_min_kept;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      cfg_reg.off_min >= `FOG_OFF_MIN;
  endproperty
  a_off_min_kept: assert property (p_off_min_kept)
    else $error("off delay below two minutes");

  property p_freq_range;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (cfg_reg.freq >= `FOG_FREQ_MIN) && (cfg_reg.freq <= `FOG_FREQ_MAX);
  endproperty
  a_freq_range: assert property (p_freq_range)
    else $error("frequency setting out of range");

  property p_resync_keeps;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (gate_reg == FOG_G_HOLD) && (stat_reg == FOG_SYNC) |=> (gate_reg == FOG_G_ON) ##1 en_reg;
  endproperty
  a_resync_keeps: assert property (p_resync_keeps)
    else $error("resync in holdover dropped output");

  property p_delays_separate;
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      (gate_reg == FOG_G_WAIT) && I_MIN_TICK && (stat_reg == FOG_SYNC)
      && (cnt_reg + 8'h01 < cfg_reg.on_min) |=> (gate_reg == FOG_G_WAIT);
  endproperty
  a_delays_separate: assert property (p_delays_separate)
    else $error("on delay ended early");
endmodule : fog_gate

// file: hdl/fog_nco.sv
// phase accumulator generating a square wave at a 1 Hz resolution setting
// assumes freq below half the core clock and a synchronous high reset
`timescale 1ns/1ps
`include "fog_params.svh"
module fog_nco
  import fog_pkg::*;
#(
  parameter int ACC_W = `FOG_ACC_W
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // control
  input  wire logic        i_run,
  input  wire logic [23:0] i_freq,
  // output
  output logic             o_wave
);
  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W-1:0] acc_next;
  logic             wave_reg;
  logic             wave_next;
  logic [ACC_W:0]   sum;

  always_comb begin
    sum       = {1'b0, acc_reg} + {{(ACC_W+1-24){1'b0}}, i_freq};
    acc_next  = acc_reg;
    wave_next = 1'b0;
    if (i_run) begin
      // modulo the clock rate: one wrap per output half period pair
      if (sum >= {1'b0, `FOG_CLK_HZ}) begin
        acc_next = ACC_W'(sum - {1'b0, `FOG_CLK_HZ});
      end else begin
        acc_next = sum[ACC_W-1:0];
      end
      wave_next = (acc_next >= ACC_W'(`FOG_CLK_HZ >> 1));
    end else begin
      acc_next = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      acc_reg  <= '0;
      wave_reg <= 1'b0;
    end else begin
      acc_reg  <= acc_next;
      wave_reg <= wave_next;
    end
  end

  assign o_wave = wave_reg;
endmodule : fog_nco

// file: hdl/fog_params.svh
// constants for the frequency output sync gate
// assumes inclusion by the package and the design files
`ifndef FOG_PARAMS_SVH
`define FOG_PARAMS_SVH
`define FOG_ADDR_FREQ      12'h000
`define FOG_ADDR_DELAY     12'h004
`define FOG_ADDR_SYNCOFF   12'h008
`define FOG_ADDR_STATUS    12'h00C
`define FOG_ADDR_CTRL      12'h010
`define FOG_FREQ_MIN       24'h000001
`define FOG_FREQ_MAX       24'h989680
`define FOG_FREQ_RST       24'h989680
`define FOG_ON_RST         8'h00
`define FOG_OFF_MIN        8'h02
`define FOG_OFF_RST        8'h02
`define FOG_SYNCOFF_MIN    14'h0002
`define FOG_SYNCOFF_RST    14'h0037
`define FOG_ACC_W          32
`define FOG_CLK_HZ         32'h017D7840
`define FOG_ON_LSB         0
`define FOG_OFF_LSB        8
`endif

// file: hdl/fog_pkg.sv
// types for the frequency output sync gate
// assumes fog_params.svh on the include path
package fog_pkg;
  `include "fog_params.svh"
  typedef enum logic [1:0] {
    FOG_SRC_LOST = 2'b00,
    FOG_QUARTZ   = 2'b01,
    FOG_REG_QTZ  = 2'b10,
    FOG_SYNC     = 2'b11
  } fog_stat_t;
  typedef enum logic [1:0] {
    FOG_G_OFF  = 2'b00,
    FOG_G_WAIT = 2'b01,
    FOG_G_ON   = 2'b10,
    FOG_G_HOLD = 2'b11
  } fog_gate_t;
  typedef struct packed {
    logic [23:0] freq;
    logic [7:0]  on_min;
    logic [7:0]  off_min;
    logic [13:0] syncoff_min;
    logic        remote_lock;
  } fog_cfg_t;
endpackage : fog_pkg
